// ### core/fars_top.v
// Fault auto restart supervisor with fan fault handling and APB registers
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Summary of operation
// - Eligible trip runs self-diagnosis, then restarts automatically when diagnosis passes.
// - Restart attempts are limited by a configurable limit, reset value zero.
// - Only the listed overcurrent, voltage, overload, overheat and torque faults may restart.
// - Undervoltage may restart only with ride-through selection one or two.
// - Any other fault keeps the protective trip without restart.
// - Digital output selected to code 1E shows the auto restart condition.
// - Attempt counter clears after ten minutes of uninterrupted running after restart.
// - Attempt counter clears on fault reset after a protective trip.
// - Attempt counter clears when power is cycled.
// - Fan fault response selection holds zero or one, reset value one.
// - Selection zero: heatsink trips as motor overheat; fan failure flashes, runs, alarms.
// - Selection one: heatsink trips as inverter overheat, fan failure as motor overheat.
// - Running on with fan failure limits rated current to eighty percent.
// - Constant torque fan run-on allows 100% three minutes, 150% fifteen seconds.
// - Variable torque fan run-on allows 100% thirty seconds, 120% ten seconds.
// - During fan failure the fan stops about three seconds every minute.
// - Auto restart operation selection is stored, reset value zero.
// ----------------------------------------------------------------
`include "fars_defines.vh"

module fars_top #(
  parameter TICK_CYCLES = `FARS_TICK_CYCLES,
  parameter CLEAR_MS    = `FARS_CLEAR_MS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [15:0] fault_vec,
  input  wire        heatsink_overheat,
  input  wire        fan_failure,
  input  wire        drive_running,
  input  wire        diag_done,
  input  wire        diag_pass,
  input  wire        fault_reset,
  input  wire [7:0]  load_pct,
  output reg         diag_request,
  output reg         restart_pulse,
  output reg         coast_stop,
  output reg         fault_out,
  output reg         alarm_out,
  output reg         fan_flash,
  output reg         fan_on,
  output reg  [7:0]  rated_current_pct,
  output reg  [4:0]  fault_code,
  output reg  [2:0]  digital_out,
  output wire        irq
);

  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_DIAG = 3'b010;
  localparam [2:0] ST_TRIP = 3'b100;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]  restart_attempt_limit;
  reg  [7:0]  restart_operation_select;
  reg         fan_fault_response_select;
  reg  [1:0]  power_loss_ride_through_select;
  reg  [1:0]  duty_rating_select;
  reg  [23:0] digital_output_function_select;
  reg  [3:0]  irq_status;
  reg  [3:0]  irq_enable;
  reg  [2:0]  state;
  reg  [7:0]  attempt_count;
  reg  [15:0] tick_cnt;
  reg         tick;
  reg  [19:0] run_ms;
  reg         restart_armed;
  reg  [15:0] fan_ms;
  reg  [17:0] ovl_ms;
  reg         fan_fail_q;
  reg  [4:0]  next_code;
  reg         next_any;
  reg  [3:0]  irq_set;
  integer     i;

  wire        apb_setup = psel & ~penable;
  wire        apb_wr    = psel & penable & pwrite;
  wire        addr_ok   = (paddr == `FARS_OFF_CONFIG) | (paddr == `FARS_OFF_OUTSEL) |
                          (paddr == `FARS_OFF_STATUS) | (paddr == `FARS_OFF_IRQ_STATUS) |
                          (paddr == `FARS_OFF_IRQ_CLEAR) | (paddr == `FARS_OFF_IRQ_ENABLE);
  wire [3:0]  irq_clear = (apb_wr && paddr == `FARS_OFF_IRQ_CLEAR) ? pwdata[3:0] : 4'h0;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign irq     = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // Fault mapping
  // ----------------------------------------------------------------
  wire fan_runon = fan_failure & ~fan_fault_response_select;
  wire sel1      = fan_fault_response_select;
  wire hot_motor = (heatsink_overheat & ~sel1) | (fan_failure & sel1);
  wire hot_inv   = heatsink_overheat & sel1;
  wire duty_ct   = (duty_rating_select == 2'h0);
  wire [7:0]  high_pct = duty_ct ? `FARS_CT_HIGH_PCT : `FARS_VT_HIGH_PCT;
  localparam [17:0] CT_LOW_MS = `FARS_CT_LOW_MS, VT_LOW_MS = `FARS_VT_LOW_MS;
  localparam [17:0] CT_HIGH_MS = `FARS_CT_HIGH_MS, VT_HIGH_MS = `FARS_VT_HIGH_MS;
  wire [17:0] low_ms   = duty_ct ? CT_LOW_MS : VT_LOW_MS;
  wire [17:0] high_ms  = duty_ct ? CT_HIGH_MS : VT_HIGH_MS;
  wire        over_hi  = load_pct >= high_pct;
  wire        over_lo  = load_pct >= `FARS_LOAD_BASE;
  wire        ovl_trip = fan_runon & ((over_hi & (ovl_ms >= high_ms)) |
                                      (over_lo & (ovl_ms >= low_ms)));

  reg  [15:0] fault_eff;
  always @*
  begin
    fault_eff = fault_vec;
    fault_eff[`FARS_F_MOTOR_HOT]    = fault_vec[`FARS_F_MOTOR_HOT] | hot_motor;
    fault_eff[`FARS_F_INV_HOT]      = fault_vec[`FARS_F_INV_HOT] | hot_inv;
    fault_eff[`FARS_F_INV_OVERLOAD] = fault_vec[`FARS_F_INV_OVERLOAD] | ovl_trip;
  end

  // Undervoltage joins the eligible set only with ride-through active
  wire        ride_on  = (power_loss_ride_through_select == 2'h1) |
                         (power_loss_ride_through_select == 2'h2);
  wire [15:0] elig_msk = `FARS_ELIGIBLE_MASK |
                         ({15'h0000, ride_on} << `FARS_F_UNDERVOLT);
  wire        fault_any = |fault_eff;
  wire        ineligible = |(fault_eff & ~elig_msk);
  wire        may_retry = ~ineligible & (attempt_count < restart_attempt_limit);

  // Lowest numbered active fault is the one reported
  always @*
  begin
    next_code = 5'h00;
    next_any  = 1'b0;
    for (i = 15; i >= 0; i = i - 1)
    begin
      if (fault_eff[i])
      begin
        next_code = i[4:0];
        next_any  = 1'b1;
      end
    end
  end

  function fars_fn_match;
    input [7:0] fn;
    begin
      case (fn)
        `FARS_FN_AUTO_RESTART: fars_fn_match = (state == ST_DIAG);
        `FARS_FN_ALARM:        fars_fn_match = fan_runon;
        `FARS_FN_FAN_FAILURE:  fars_fn_match = fan_failure;
        default:               fars_fn_match = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end
    else if (tick_cnt == TICK_CYCLES[15:0] - 16'h0001)
    begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Restart state machine and attempt counter
  // ----------------------------------------------------------------
  wire run_done = restart_armed & tick & (run_ms == CLEAR_MS[19:0] - 20'h00001);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state         <= ST_RUN;
      attempt_count <= 8'h00;
      restart_armed <= 1'b0;
      run_ms        <= 20'h00000;
      restart_pulse <= 1'b0;
      fault_code    <= 5'h00;
      irq_set       <= 4'h0;
    end
    else
    begin
      restart_pulse <= 1'b0;
      irq_set       <= 4'h0;
      case (state)
        ST_RUN:
        begin
          if (fault_any)
          begin
            fault_code    <= next_code;
            restart_armed <= 1'b0;
            run_ms        <= 20'h00000;
            if (may_retry)
              state <= ST_DIAG;
            else
            begin
              state      <= ST_TRIP;
              irq_set[`FARS_IRQ_TRIP] <= 1'b1;
            end
          end
          else if (restart_armed & ~drive_running)
            run_ms <= 20'h00000;
          else if (run_done)
          begin
            attempt_count <= 8'h00;
            restart_armed <= 1'b0;
            run_ms        <= 20'h00000;
            irq_set[`FARS_IRQ_CNT_CLEAR] <= 1'b1;
          end
          else if (restart_armed & tick)
            run_ms <= run_ms + 20'h00001;
        end
        ST_DIAG:
        begin
          if (diag_done)
          begin
            if (diag_pass)
            begin
              state         <= ST_RUN;
              attempt_count <= attempt_count + 8'h01;
              restart_armed <= 1'b1;
              restart_pulse <= 1'b1;
              irq_set[`FARS_IRQ_RESTART] <= 1'b1;
            end
            else
            begin
              state <= ST_TRIP;
              irq_set[`FARS_IRQ_TRIP] <= 1'b1;
            end
          end
        end
        ST_TRIP:
        begin
          if (fault_reset)
          begin
            state         <= ST_RUN;
            attempt_count <= 8'h00;
          end
        end
        default:
          state <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fan interval run and overload timing
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fan_ms <= 16'h0000;
      ovl_ms <= 18'h00000;
    end
    else
    begin
      if (!fan_failure)
        fan_ms <= 16'h0000;
      else if (tick)
        fan_ms <= (fan_ms == `FARS_FAN_PERIOD_MS - 1) ? 16'h0000 : fan_ms + 16'h0001;
      // Time above the base rating; drops back once load falls below it
      if (!fan_runon || !over_lo)
        ovl_ms <= 18'h00000;
      else if (tick && ovl_ms != 18'h3FFFF)
        ovl_ms <= ovl_ms + 18'h00001;
    end
  end

  // ----------------------------------------------------------------
  // Drive outputs
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      diag_request      <= 1'b0;
      coast_stop        <= 1'b0;
      fault_out         <= 1'b0;
      alarm_out         <= 1'b0;
      fan_flash         <= 1'b0;
      fan_on            <= 1'b1;
      rated_current_pct <= `FARS_FULL_PCT;
      digital_out       <= 3'h0;
      fan_fail_q        <= 1'b0;
    end
    else
    begin
      diag_request      <= (state == ST_DIAG);
      coast_stop        <= (state != ST_RUN);
      fault_out         <= (state == ST_TRIP);
      alarm_out         <= fan_runon;
      fan_flash         <= fan_runon;
      fan_on            <= ~(fan_failure & (fan_ms < `FARS_FAN_STOP_MS));
      rated_current_pct <= fan_runon ? `FARS_DERATED_PCT : `FARS_FULL_PCT;
      digital_out[0]    <= fars_fn_match(digital_output_function_select[7:0]);
      digital_out[1]    <= fars_fn_match(digital_output_function_select[15:8]);
      digital_out[2]    <= fars_fn_match(digital_output_function_select[23:16]);
      fan_fail_q        <= fan_failure;
    end
  end

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      restart_attempt_limit          <= `FARS_RST_LIMIT;
      restart_operation_select       <= `FARS_RST_OPSEL;
      fan_fault_response_select      <= `FARS_RST_FANSEL;
      power_loss_ride_through_select <= `FARS_RST_RIDE;
      duty_rating_select             <= `FARS_RST_DUTY;
      digital_output_function_select <= {3{`FARS_RST_OUTSEL}};
      irq_enable                     <= 4'h0;
    end
    else if (apb_wr)
    begin
      if (paddr == `FARS_OFF_CONFIG)
      begin
        restart_attempt_limit          <= pwdata[`FARS_CFG_LIMIT_LSB +: 8];
        restart_operation_select       <= pwdata[`FARS_CFG_OPSEL_LSB +: 8];
        fan_fault_response_select      <= pwdata[`FARS_CFG_FANSEL_BIT];
        power_loss_ride_through_select <= pwdata[`FARS_CFG_RIDE_LSB +: 2];
        duty_rating_select             <= pwdata[`FARS_CFG_DUTY_LSB +: 2];
      end
      if (paddr == `FARS_OFF_OUTSEL)
        digital_output_function_select <= pwdata[23:0];
      if (paddr == `FARS_OFF_IRQ_ENABLE)
        irq_enable <= pwdata[3:0];
    end
  end

  // Set beats clear so an event coinciding with a clear is kept
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= 4'h0;
    else
      irq_status <= (irq_status & ~irq_clear) | irq_set |
                    {fan_failure & ~fan_fail_q, 3'h0};
  end

  // Read data is captured in the setup cycle and stands in the access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (apb_setup && !pwrite)
    begin
      case (paddr)
        `FARS_OFF_CONFIG:
          prdata <= {11'h000, duty_rating_select, power_loss_ride_through_select,
                     fan_fault_response_select, restart_operation_select,
                     restart_attempt_limit};
        `FARS_OFF_OUTSEL:     prdata <= {8'h00, digital_output_function_select};
        `FARS_OFF_STATUS:
          prdata <= {9'h000, fan_on, fan_runon, fault_code, 5'h00, state, attempt_count};
        `FARS_OFF_IRQ_STATUS: prdata <= {28'h0000000, irq_status};
        `FARS_OFF_IRQ_ENABLE: prdata <= {28'h0000000, irq_enable};
        default:              prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // fars_top

// ### core/fars_defines.vh
// Constants for the fault auto restart supervisor
`ifndef FARS_DEFINES_VH
`define FARS_DEFINES_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FARS_OFF_CONFIG      8'h00
`define FARS_OFF_OUTSEL      8'h04
`define FARS_OFF_STATUS      8'h08
`define FARS_OFF_IRQ_STATUS  8'h0C
`define FARS_OFF_IRQ_CLEAR   8'h10
`define FARS_OFF_IRQ_ENABLE  8'h14
// ----------------------------------------------------------------
// Configuration fields and reset values
// ----------------------------------------------------------------
`define FARS_CFG_LIMIT_LSB   0
`define FARS_CFG_OPSEL_LSB   8
`define FARS_CFG_FANSEL_BIT  16
`define FARS_CFG_RIDE_LSB    17
`define FARS_CFG_DUTY_LSB    19
`define FARS_RST_LIMIT       8'h00
`define FARS_RST_OPSEL       8'h00
`define FARS_RST_FANSEL      1'b1
`define FARS_RST_RIDE        2'h0
`define FARS_RST_DUTY        2'h0
`define FARS_RST_OUTSEL      8'h00
// ----------------------------------------------------------------
// Output function codes
// ----------------------------------------------------------------
`define FARS_FN_AUTO_RESTART 8'h1E
`define FARS_FN_ALARM        8'h10
`define FARS_FN_FAN_FAILURE  8'h3D
// ----------------------------------------------------------------
// Fault vector positions
// ----------------------------------------------------------------
`define FARS_F_UNDERVOLT     4
`define FARS_F_INV_OVERLOAD  10
`define FARS_F_MOTOR_HOT     11
`define FARS_F_INV_HOT       14
`define FARS_ELIGIBLE_MASK   16'h3FEF
// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define FARS_IRQ_RESTART     0
`define FARS_IRQ_TRIP        1
`define FARS_IRQ_CNT_CLEAR   2
`define FARS_IRQ_FAN_FAIL    3
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FARS_CLK_NS          25
`define FARS_TICK_NS         1000000
`define FARS_TICK_CYCLES     (`FARS_TICK_NS / `FARS_CLK_NS)
`define FARS_CLEAR_MIN       10
`define FARS_CLEAR_MS        (`FARS_CLEAR_MIN * 60000)
`define FARS_FAN_PERIOD_S    60
`define FARS_FAN_PERIOD_MS   (`FARS_FAN_PERIOD_S * 1000)
`define FARS_FAN_STOP_S      3
`define FARS_FAN_STOP_MS     (`FARS_FAN_STOP_S * 1000)
`define FARS_CT_LOW_MIN      3
`define FARS_CT_LOW_MS       (`FARS_CT_LOW_MIN * 60000)
`define FARS_CT_HIGH_S       15
`define FARS_CT_HIGH_MS      (`FARS_CT_HIGH_S * 1000)
`define FARS_VT_LOW_S        30
`define FARS_VT_LOW_MS       (`FARS_VT_LOW_S * 1000)
`define FARS_VT_HIGH_S       10
`define FARS_VT_HIGH_MS      (`FARS_VT_HIGH_S * 1000)
`define FARS_LOAD_BASE       8'd100
`define FARS_CT_HIGH_PCT     8'd150
`define FARS_VT_HIGH_PCT     8'd120
`define FARS_DERATED_PCT     8'd80
`define FARS_FULL_PCT        8'd100
`endif

// ### bench/fars_top_sva.sv
// Port-level assertion checker for the fault auto restart supervisor
`timescale 1ns/1ps
module fars_top_sva #(
  parameter TICK_CYCLES = 4
) (
  input wire        pclk,
  input wire        presetn,
  input wire [15:0] fault_vec,
  input wire        fan_failure,
  input wire        diag_done,
  input wire        diag_pass,
  input wire        diag_request,
  input wire        restart_pulse,
  input wire        coast_stop,
  input wire        fault_out,
  input wire        alarm_out,
  input wire        fan_flash,
  input wire        fan_on,
  input wire [7:0]  rated_current_pct
);
  // One spare tick: the stop window is aligned to the tick
  localparam int STOP_MAX = 3001 * TICK_CYCLES;
  int stop_run;

  always @(posedge pclk or negedge presetn)
    if (!presetn)
      stop_run <= 0;
    else
      stop_run <= fan_on ? 0 : stop_run + 1;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pass;
    diag_request && diag_done && diag_pass;
  endsequence
  sequence s_fail;
    diag_request && diag_done && !diag_pass;
  endsequence

  property p_restart; s_pass |=> restart_pulse; endproperty
  property p_fail_trip; s_fail |-> ##2 fault_out; endproperty
  property p_single; restart_pulse |-> $past(diag_pass) ##1 !restart_pulse; endproperty
  property p_diag_coast; diag_request |-> coast_stop && !fault_out; endproperty
  property p_trip_coast; fault_out |-> coast_stop && !diag_request; endproperty
  property p_ineligible;
    ($rose(fault_vec[15]) && !coast_stop && $past(fault_vec) == 16'h0000)
      |-> ##2 (fault_out && !diag_request);
  endproperty
  property p_alarm; alarm_out |-> $past(fan_failure) && fan_flash; endproperty
  property p_derate;
    rated_current_pct != 8'd100 |-> rated_current_pct == 8'd80 && $past(fan_failure);
  endproperty
  property p_fan_stop; !fan_on |-> $past(fan_failure) && stop_run <= STOP_MAX; endproperty

  a_restart: assert property (p_restart)
    else $error("no restart after passed diagnosis");
  a_fail_trip: assert property (p_fail_trip)
    else $error("failed diagnosis did not trip");
  a_single: assert property (p_single)
    else $error("restart pulse without pass or too long");
  a_diag_coast: assert property (p_diag_coast)
    else $error("diagnosis while running or tripped");
  a_trip_coast: assert property (p_trip_coast)
    else $error("trip without coasting");
  a_ineligible: assert property (p_ineligible)
    else $error("ineligible fault not tripped");
  a_alarm: assert property (p_alarm)
    else $error("alarm without fan failure");
  a_derate: assert property (p_derate)
    else $error("bad rated current");
  a_fan_stop: assert property (p_fan_stop)
    else $error("fan stop too long or unprompted");
endmodule // fars_top_sva

bind fars_top fars_top_sva #(.TICK_CYCLES(TICK_CYCLES)) u_fars_sva (
  .pclk(pclk), .presetn(presetn), .fault_vec(fault_vec), .fan_failure(fan_failure),
  .diag_done(diag_done), .diag_pass(diag_pass), .diag_request(diag_request),
  .restart_pulse(restart_pulse), .coast_stop(coast_stop), .fault_out(fault_out),
  .alarm_out(alarm_out), .fan_flash(fan_flash), .fan_on(fan_on),
  .rated_current_pct(rated_current_pct));

// ### bench/test_fault_auto_restart_supervisor.sv
// Self-checking testbench for the fault auto restart supervisor
`timescale 1ns/1ps
`include "fars_defines.vh"
module test_fault_auto_restart_supervisor;
  localparam TICK = 4;
  localparam CLR  = 20;
  reg         pclk = 1'b0, presetn = 1'b0;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00, load_pct = 8'h00;
  reg  [31:0] pwdata = 32'h00000000;
  reg  [15:0] fault_vec = 16'h0000;
  reg         heatsink_overheat = 1'b0, fan_failure = 1'b0, drive_running = 1'b0;
  reg         diag_done = 1'b0, diag_pass = 1'b0, fault_reset = 1'b0;
  wire [31:0] prdata;
  wire        pready, pslverr, diag_request, restart_pulse, coast_stop, fault_out;
  wire        alarm_out, fan_flash, fan_on, irq;
  wire [7:0]  rated_current_pct;
  wire [4:0]  fault_code;
  wire [2:0]  digital_out;
  integer     mismatches = 0, n_compared = 0, n_restart = 0, cycles = 0, i, b;
  reg  [31:0] q;
  reg         e;

  fars_top #(.TICK_CYCLES(TICK), .CLEAR_MS(CLR)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_vec(fault_vec), .heatsink_overheat(heatsink_overheat),
    .fan_failure(fan_failure), .drive_running(drive_running), .diag_done(diag_done),
    .diag_pass(diag_pass), .fault_reset(fault_reset), .load_pct(load_pct),
    .diag_request(diag_request), .restart_pulse(restart_pulse), .coast_stop(coast_stop),
    .fault_out(fault_out), .alarm_out(alarm_out), .fan_flash(fan_flash), .fan_on(fan_on),
    .rated_current_pct(rated_current_pct), .fault_code(fault_code),
    .digital_out(digital_out), .irq(irq));

  always #12.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Monitors and closing
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    cycles = cycles + 1;
    if (restart_pulse === 1'b1)
      n_restart = n_restart + 1;
    // Whole run needs about 41000 cycles
    if (cycles == 60000)
    begin
      mismatches = mismatches + 1;
      results;
    end
  end

  task results;
    begin
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask

  task apb(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdm(input [7:0] a, input [31:0] m, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h00000000);
      check(q & m, exp);
    end
  endtask

  task hit(input integer bit_no);
    begin
      fault_vec[bit_no] <= 1'b1;
      @(posedge pclk);
      fault_vec <= 16'h0000;
      cyc(3);
    end
  endtask

  task diag(input ok);
    begin
      diag_done <= 1'b1;
      diag_pass <= ok;
      @(posedge pclk);
      diag_done <= 1'b0;
      cyc(3);
    end
  endtask

  task clr;
    begin
      fault_reset <= 1'b1;
      @(posedge pclk);
      fault_reset <= 1'b0;
      cyc(3);
    end
  endtask

  task hs(input [31:0] cfg, input h, input f, input [4:0] code);
    begin
      wr(`FARS_OFF_CONFIG, cfg);
      heatsink_overheat <= h;
      fan_failure       <= f;
      cyc(4);
      check({fault_out, coast_stop}, 2'b11);
      rdm(`FARS_OFF_STATUS, 32'h001F0000, {11'h000, code, 16'h0000});
      heatsink_overheat <= 1'b0;
      fan_failure       <= 1'b0;
      clr;
    end
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    cyc(4);
    presetn <= 1'b1;
    rdm(`FARS_OFF_CONFIG, 32'hFFFFFFFF, 32'h00010000);
    rdm(`FARS_OFF_STATUS, 32'hFFFFFFFF, 32'h00400100);
    apb(1'b0, 8'h18, 32'h00000000);
    check(e, 1'b1);
    check(q, 32'h00000000);
    hit(0);
    check({diag_request, fault_out}, 2'b01);
    clr;
    $display("test reset and zero limit done");

    for (i = 0; i < 17; i = i + 1)
    begin
      b = (i == 16) ? 4 : i;
      // Undervoltage goes again with ride-through on
      wr(`FARS_OFF_CONFIG, (i == 16) ? 32'h00030001 : 32'h00010001);
      hit(b);
      check(diag_request, `FARS_ELIGIBLE_MASK >> b & 1 | i == 16);
      if (diag_request === 1'b1)
        diag(1'b0);
      check(fault_out, 1'b1);
      clr;
    end
    $display("test eligibility done");

    wr(`FARS_OFF_CONFIG, 32'h00010002);
    wr(`FARS_OFF_OUTSEL, 32'h003D101E);
    for (i = 1; i < 3; i = i + 1)
    begin
      hit(0);
      check(digital_out, 3'b001);
      diag(1'b1);
      check(n_restart, i);
      rdm(`FARS_OFF_STATUS, 32'h000007FF, 32'h00000100 | i);
    end
    check(digital_out, 3'b000);
    hit(0);
    check(fault_out, 1'b1);
    clr;
    rdm(`FARS_OFF_STATUS, 32'h000007FF, 32'h00000100);
    $display("test restart limit done");

    wr(`FARS_OFF_CONFIG, 32'h00010001);
    wr(`FARS_OFF_IRQ_CLEAR, 32'h0000000F);
    wr(`FARS_OFF_IRQ_ENABLE, 32'h00000000);
    drive_running <= 1'b1;
    hit(0);
    diag(1'b1);
    cyc(40);
    rdm(`FARS_OFF_STATUS, 32'h000000FF, 32'h00000001);
    cyc(60);
    rdm(`FARS_OFF_STATUS, 32'h000000FF, 32'h00000000);
    rdm(`FARS_OFF_IRQ_STATUS, 32'h00000004, 32'h00000004);
    check(irq, 1'b0);
    wr(`FARS_OFF_IRQ_ENABLE, 32'h00000004);
    // Register updates land at the access edge; look one cycle later
    cyc(1);
    check(irq, 1'b1);
    wr(`FARS_OFF_IRQ_CLEAR, 32'h00000004);
    cyc(1);
    check(irq, 1'b0);
    rdm(`FARS_OFF_IRQ_CLEAR, 32'hFFFFFFFF, 32'h00000000);
    drive_running <= 1'b0;
    hit(0);
    diag(1'b1);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    rdm(`FARS_OFF_STATUS, 32'h000000FF, 32'h00000000);
    $display("test run-time clear and power cycle done");

    hs(32'h00010000, 1'b1, 1'b0, `FARS_F_INV_HOT);
    hs(32'h00000000, 1'b1, 1'b0, `FARS_F_MOTOR_HOT);
    hs(32'h00010000, 1'b0, 1'b1, `FARS_F_MOTOR_HOT);
    $display("test fan selection codes done");

    wr(`FARS_OFF_OUTSEL, 32'h003D101E);
    wr(`FARS_OFF_CONFIG, 32'h00080000);
    load_pct    <= 8'd120;
    fan_failure <= 1'b1;
    cyc(4);
    check({alarm_out, fan_flash, fault_out, fan_on, coast_stop}, 5'b11000);
    check(rated_current_pct, 8'd80);
    check(digital_out, 3'b110);
    cyc(11896);
    check(fan_on, 1'b0);
    cyc(200);
    check(fan_on, 1'b1);
    cyc(27700);
    check(fault_out, 1'b0);
    cyc(400);
    check({fault_out, fault_code}, {1'b1, 5'd10});
    $display("test fan run-on done");
    results;
  end
endmodule // test_fault_auto_restart_supervisor
